/* File: design/saw_top.sv */
// Angle word holding registers, CPU control registers and two channel sequencers
`timescale 1ns/1ps
module saw_top
  import saw_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // Angle processor result bus and load strobes
  input wire logic [saw_pkg::WORD_W-1:0] ANGLE_PROC_WORD,
  input wire logic SINE_LOAD_N,
  input wire logic COSINE_LOAD_N,
  input wire logic ANGLE_LOAD_N,
  // CPU data lines and write strobes
  input wire logic [saw_pkg::CPU_DATA_W-1:0] CPU_DATA_LINES,
  input wire logic SIN_CTRL_WR_N,
  input wire logic COS_CTRL_WR_N,
  input wire logic LEVEL_WR_N,
  // Track-and-hold settling length in clocks
  input wire logic [saw_pkg::SETTLE_W-1:0] SETTLE_COUNT,
  // Sine channel drive
  output logic SIN_POLARITY,
  output logic [saw_pkg::TAP_W-1:0] SIN_TAP_SEL,
  output logic [saw_pkg::FINE_W-1:0] SIN_FINE_CODE,
  output logic SIN_HOLD,
  // Cosine channel drive
  output logic COS_POLARITY,
  output logic [saw_pkg::TAP_W-1:0] COS_TAP_SEL,
  output logic [saw_pkg::FINE_W-1:0] COS_FINE_CODE,
  output logic COS_HOLD,
  // Rear angle output
  output logic [saw_pkg::WORD_W-1:0] ANGLE_OUT,
  // Control and level codes
  output logic [saw_pkg::SIN_CTRL_W-1:0] SIN_CTRL_OUT,
  output logic [saw_pkg::COS_CTRL_W-1:0] COS_CTRL_OUT,
  output logic [saw_pkg::LEVEL_W-1:0] LEVEL_CODE
);
  import saw_pkg::*;

  localparam int NCHAN = 2;

  // Processor side synchronisers
  logic [WORD_W-1:0] word_s1;
  logic [WORD_W-1:0] word_s2;
  logic [2:0] pstb_s1;
  logic [2:0] pstb_s2;

  // CPU side synchronisers
  logic [CPU_DATA_W-1:0] cpu_s1;
  logic [CPU_DATA_W-1:0] cpu_s2;
  logic [2:0] cstb_s1;
  logic [2:0] cstb_s2;

  // Holding registers
  logic [WORD_W-1:0] sine_word;
  logic [WORD_W-1:0] cosine_word;
  logic [WORD_W-1:0] angle_word;

  // Decoded load enables, active high
  wire sine_ld = ~pstb_s2[0];
  wire cosine_ld = ~pstb_s2[1];
  wire angle_ld = ~pstb_s2[2];
  wire sctrl_wr = ~cstb_s2[0];
  wire cctrl_wr = ~cstb_s2[1];
  wire level_wr = ~cstb_s2[2];

  // Both pin groups come from foreign clocks, so every bit passes two flops
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      word_s1 <= WORD_RST;
      word_s2 <= WORD_RST;
    end
    else
    begin
      word_s1 <= ANGLE_PROC_WORD;
      word_s2 <= word_s1;
    end
  end

  // Strobes idle high, so reset parks them inactive
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      pstb_s1 <= 3'h7;
      pstb_s2 <= 3'h7;
    end
    else
    begin
      pstb_s1 <= {ANGLE_LOAD_N, COSINE_LOAD_N, SINE_LOAD_N};
      pstb_s2 <= pstb_s1;
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      cpu_s1 <= CTRL_RST;
      cpu_s2 <= CTRL_RST;
    end
    else
    begin
      cpu_s1 <= CPU_DATA_LINES;
      cpu_s2 <= cpu_s1;
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      cstb_s1 <= 3'h7;
      cstb_s2 <= 3'h7;
    end
    else
    begin
      cstb_s1 <= {LEVEL_WR_N, COS_CTRL_WR_N, SIN_CTRL_WR_N};
      cstb_s2 <= cstb_s1;
    end
  end

  // Data and strobe share the same delay; data must stay put while strobe low
  // Shared word lands only in the register whose strobe is low
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      sine_word <= WORD_RST;
    else if (sine_ld)
      sine_word <= word_s2;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      cosine_word <= WORD_RST;
    else if (cosine_ld)
      cosine_word <= word_s2;
  end

  // Angle word is held and driven out unchanged
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      angle_word <= WORD_RST;
    else if (angle_ld)
      angle_word <= word_s2;
  end

  assign ANGLE_OUT = angle_word;

  // Sine control uses the low byte, cosine control the full word
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      SIN_CTRL_OUT <= CTRL_RST[SIN_CTRL_W-1:0];
    else if (sctrl_wr)
      SIN_CTRL_OUT <= cpu_s2[SIN_CTRL_W-1:0];
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      COS_CTRL_OUT <= CTRL_RST;
    else if (cctrl_wr)
      COS_CTRL_OUT <= cpu_s2[COS_CTRL_W-1:0];
  end

  // Line-to-line level takes data lines 0 to 11
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      LEVEL_CODE <= LEVEL_RST;
    else if (level_wr)
      LEVEL_CODE <= cpu_s2[LEVEL_W-1:0];
  end

  // Per-channel sequencers; index 0 is sine, 1 is cosine
  logic [WORD_W-1:0] chan_word [NCHAN];
  logic chan_pol_o [NCHAN];
  logic [TAP_W-1:0] chan_tap_o [NCHAN];
  logic [FINE_W-1:0] chan_fine_o [NCHAN];
  logic chan_hold_o [NCHAN];

  assign chan_word[0] = sine_word;
  assign chan_word[1] = cosine_word;

  // Each channel follows its held word; real-time rewrites just restart a hold
  generate
    for (genvar g = 0; g < NCHAN; g++)
    begin : g_chan
      saw_chan_if cif ();

      assign cif.word = chan_word[g];
      assign cif.settle = SETTLE_COUNT;
      assign chan_pol_o[g] = cif.polarity;
      assign chan_tap_o[g] = cif.tap;
      assign chan_fine_o[g] = cif.fine;
      assign chan_hold_o[g] = cif.hold;

      saw_chan u_chan
      (
        .clk(CORE_CLK),
        .rst(RST),
        .bus(cif.chan)
      );
    end
  endgenerate

  // Drive codes straight from the sequencer flops
  assign SIN_POLARITY = chan_pol_o[0];
  assign SIN_TAP_SEL = chan_tap_o[0];
  assign SIN_FINE_CODE = chan_fine_o[0];
  assign SIN_HOLD = chan_hold_o[0];
  assign COS_POLARITY = chan_pol_o[1];
  assign COS_TAP_SEL = chan_tap_o[1];
  assign COS_FINE_CODE = chan_fine_o[1];
  assign COS_HOLD = chan_hold_o[1];

endmodule // saw_top

/* File: inc/saw_pkg.sv */
// Constants, types and field decoders for the synchro angle word registers
// How it works
// - Each register loads only on own strobe
// - Four-bit coarse code selects transformer tap
// - Sixteen-bit fine code drives multiplying converter
// - Twenty magnitude bits plus sign selects polarity
// - Hold output across every code transition
// - Angle register drives rear angle output
// - CPU writes sine and cosine control words
// - CPU writes twelve-bit line level code
package saw_pkg;

  localparam int WORD_W = 24;
  localparam int CODE_W = 21;
  localparam int TAP_W = 4;
  localparam int FINE_W = 16;
  localparam int SIN_CTRL_W = 8;
  localparam int COS_CTRL_W = 16;
  localparam int LEVEL_W = 12;
  localparam int CPU_DATA_W = 16;
  localparam int SETTLE_W = 8;

  // Field positions inside a channel word
  localparam int POL_POS = 20;
  localparam int TAP_LSB = 16;
  localparam int FINE_LSB = 0;

  // Reset values
  localparam logic [WORD_W-1:0] WORD_RST = 24'h000000;
  localparam logic [COS_CTRL_W-1:0] CTRL_RST = 16'h0000;
  localparam logic [LEVEL_W-1:0] LEVEL_RST = 12'h000;

  // Settling count used when the supplied count is zero
  localparam logic [SETTLE_W-1:0] SETTLE_MIN = 8'h01;

  typedef enum logic [1:0]
  {
    SAW_IDLE = 2'b00,
    SAW_ARM = 2'b01,
    SAW_SETTLE = 2'b10
  } saw_state_t;

  function automatic logic chan_pol(input logic [WORD_W-1:0] w);
    chan_pol = w[POL_POS];
  endfunction

  function automatic logic [TAP_W-1:0] chan_tap(input logic [WORD_W-1:0] w);
    chan_tap = w[TAP_LSB +: TAP_W];
  endfunction

  function automatic logic [FINE_W-1:0] chan_fine(input logic [WORD_W-1:0] w);
    chan_fine = w[FINE_LSB +: FINE_W];
  endfunction

  function automatic logic [CODE_W-1:0] chan_code(input logic [WORD_W-1:0] w);
    chan_code = w[CODE_W-1:0];
  endfunction

endpackage

/* File: inc/saw_chan_if.sv */
// Carrier between the register top and one channel sequencer
`timescale 1ns/1ps
interface saw_chan_if;
  import saw_pkg::*;
  logic [WORD_W-1:0] word;
  logic [SETTLE_W-1:0] settle;
  logic polarity;
  logic [TAP_W-1:0] tap;
  logic [FINE_W-1:0] fine;
  logic hold;

  modport ctl
  (
    output word,
    output settle,
    input polarity,
    input tap,
    input fine,
    input hold
  );

  modport chan
  (
    input word,
    input settle,
    output polarity,
    output tap,
    output fine,
    output hold
  );
endinterface

/* File: design/saw_chan.sv */
// Channel sequencer: splits a held word and masks code changes with track-and-hold
`timescale 1ns/1ps
module saw_chan
  import saw_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Word in, drive codes out
  saw_chan_if.chan bus
);

  saw_state_t state;
  saw_state_t next_state;
  logic [WORD_W-1:0] pending;
  logic [SETTLE_W-1:0] cnt;
  logic [CODE_W-1:0] applied;

  wire [CODE_W-1:0] word_code = chan_code(bus.word);
  wire changed_idle = (word_code != applied);
  wire changed_hold = (word_code != chan_code(pending));
  wire [SETTLE_W-1:0] settle_eff = (bus.settle == '0) ? SETTLE_MIN : bus.settle;
  wire settle_done = (cnt == SETTLE_MIN);

  assign applied = {bus.polarity, bus.tap, bus.fine};

  always_comb
  begin
    next_state = state;
    unique case (state)
      SAW_IDLE:
        if (changed_idle)
          next_state = SAW_ARM;
      SAW_ARM:
        next_state = SAW_SETTLE;
      SAW_SETTLE:
        if (changed_hold)
          next_state = SAW_ARM;
        else if (settle_done)
          next_state = SAW_IDLE;
      default:
        next_state = SAW_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      state <= SAW_IDLE;
    else
      state <= next_state;
  end

  // Hold rises one clock before the new code reaches the outputs
  always_ff @(posedge clk)
  begin
    if (rst)
      bus.hold <= 1'b0;
    else if (state == SAW_IDLE && changed_idle)
      bus.hold <= 1'b1;
    else if (state == SAW_SETTLE && !changed_hold && settle_done)
      bus.hold <= 1'b0;
  end

  // A change during settling restarts the window rather than slipping through
  always_ff @(posedge clk)
  begin
    if (rst)
      pending <= WORD_RST;
    else if ((state == SAW_IDLE && changed_idle) || (state == SAW_SETTLE && changed_hold))
      pending <= bus.word;
  end

  // Split into sign, coarse tap and fine code
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      bus.polarity <= 1'b0;
      bus.tap <= '0;
      bus.fine <= '0;
    end
    else if (state == SAW_ARM)
    begin
      bus.polarity <= chan_pol(pending);
      bus.tap <= chan_tap(pending);
      bus.fine <= chan_fine(pending);
    end
  end

  // Settling count, reloaded each time a code is applied
  always_ff @(posedge clk)
  begin
    if (rst)
      cnt <= SETTLE_MIN;
    else if (state == SAW_ARM)
      cnt <= settle_eff;
    else if (state == SAW_SETTLE && !settle_done)
      cnt <= cnt - SETTLE_MIN;
  end

endmodule // saw_chan

/* File: tb/saw_checker.sv */
// Port-level assertions for the synchro angle word registers
`timescale 1ns/1ps
module saw_checker
  import saw_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // Inputs
  input wire logic [saw_pkg::WORD_W-1:0] ANGLE_PROC_WORD,
  input wire logic SINE_LOAD_N,
  input wire logic ANGLE_LOAD_N,
  input wire logic [saw_pkg::CPU_DATA_W-1:0] CPU_DATA_LINES,
  input wire logic SIN_CTRL_WR_N,
  input wire logic LEVEL_WR_N,
  input wire logic [saw_pkg::SETTLE_W-1:0] SETTLE_COUNT,
  // Outputs
  input wire logic SIN_POLARITY,
  input wire logic [saw_pkg::TAP_W-1:0] SIN_TAP_SEL,
  input wire logic [saw_pkg::FINE_W-1:0] SIN_FINE_CODE,
  input wire logic SIN_HOLD,
  input wire logic [saw_pkg::WORD_W-1:0] ANGLE_OUT,
  input wire logic [saw_pkg::SIN_CTRL_W-1:0] SIN_CTRL_OUT,
  input wire logic [saw_pkg::LEVEL_W-1:0] LEVEL_CODE
);
  logic [CODE_W-1:0] sin_code;
  logic [15:0] since;
  assign sin_code = {SIN_POLARITY, SIN_TAP_SEL, SIN_FINE_CODE};
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);
  // Edges since the sine codes last moved
  always_ff @(posedge CORE_CLK)
    since <= $stable(sin_code) ? since + 16'h0001 : 16'h0001;
  // One load pulse, then quiet long enough for the codes to land
  sequence sin_strobe_s;
    !SINE_LOAD_N ##1 SINE_LOAD_N [*6];
  endsequence
  angle_load_a: assert property (!ANGLE_LOAD_N |-> ##3 ANGLE_OUT == $past(ANGLE_PROC_WORD, 3))
    else $error("angle register missed a load");
  angle_keep_a: assert property (ANGLE_LOAD_N |-> ##3 $stable(ANGLE_OUT))
    else $error("angle register changed without strobe");
  sin_ctrl_a: assert property (!SIN_CTRL_WR_N |-> ##3 SIN_CTRL_OUT == SIN_CTRL_W'($past(CPU_DATA_LINES, 3)))
    else $error("sine control missed a write");
  level_code_a: assert property (!LEVEL_WR_N |-> ##3 LEVEL_CODE == LEVEL_W'($past(CPU_DATA_LINES, 3)))
    else $error("level code missed a write");
  sin_word_a: assert property (sin_strobe_s |-> sin_code == CODE_W'($past(ANGLE_PROC_WORD, 6)))
    else $error("sine codes do not match loaded word");
  hold_lead_a: assert property ($rose(SIN_HOLD) |=> sin_code != $past(sin_code))
    else $error("hold rose without a code change next");
  code_masked_a: assert property (!$stable(sin_code) && !$past(RST) |-> SIN_HOLD && $past(SIN_HOLD))
    else $error("sine codes changed outside hold");
  hold_len_a: assert property ($fell(SIN_HOLD) && !$past(RST) |->
    since == ((SETTLE_COUNT == 8'h00) ? 16'h0001 : 16'(SETTLE_COUNT)))
    else $error("hold length wrong");
endmodule // saw_checker

bind saw_top saw_checker chk_i (.*);

/* File: tb/saw_proc_model.sv */
// Angle processor and CPU write model driving the register inputs
`timescale 1ns/1ps
module saw_proc_model
  import saw_pkg::*;
(
  // Request from the bench
  input wire logic clk,
  input wire logic go,
  input wire logic [2:0] kind,
  input wire logic [saw_pkg::WORD_W-1:0] val,
  // Pins
  output logic [saw_pkg::WORD_W-1:0] word,
  output logic [saw_pkg::CPU_DATA_W-1:0] data,
  output logic [5:0] ld_n
);
  int age = 9;
  logic [WORD_W-1:0] word_q = '0;
  logic [CPU_DATA_W-1:0] data_q = '0;
  logic [5:0] ld_q = 6'h3F;
  assign word = word_q;
  assign data = data_q;
  assign ld_n = ld_q;
  // Single driver per pin; one strobe low for one cycle, the rest parked high
  always @(negedge clk)
  begin
    ld_q <= go ? ~(6'h01 << kind) : 6'h3F;
    age <= go ? 0 : age + 1;
    if (go)
    begin
      word_q <= val;
      data_q <= val[CPU_DATA_W-1:0];
    end
    else if (age == 3)
    begin
      // Released bus: no stale value left to pass by luck
      word_q <= ~word_q;
      data_q <= ~data_q;
    end
  end
endmodule // saw_proc_model

/* File: tb/synchro_angle_word_registers_tb.sv */
// Self-checking bench for the synchro angle word registers
`timescale 1ns/1ps
module synchro_angle_word_registers_tb;
  import saw_pkg::*;
  logic CORE_CLK = 1'b0;
  logic RST = 1'b1;
  logic [SETTLE_W-1:0] SETTLE_COUNT = 8'h01;
  wire [WORD_W-1:0] ANGLE_PROC_WORD;
  wire [CPU_DATA_W-1:0] CPU_DATA_LINES;
  wire SINE_LOAD_N, COSINE_LOAD_N, ANGLE_LOAD_N, SIN_CTRL_WR_N, COS_CTRL_WR_N, LEVEL_WR_N;
  logic SIN_POLARITY, SIN_HOLD, COS_POLARITY, COS_HOLD;
  logic [TAP_W-1:0] SIN_TAP_SEL, COS_TAP_SEL;
  logic [FINE_W-1:0] SIN_FINE_CODE, COS_FINE_CODE;
  logic [WORD_W-1:0] ANGLE_OUT;
  logic [SIN_CTRL_W-1:0] SIN_CTRL_OUT;
  logic [COS_CTRL_W-1:0] COS_CTRL_OUT;
  logic [LEVEL_W-1:0] LEVEL_CODE;
  logic go = 1'b0;
  logic [2:0] kind = 3'h0;
  logic [WORD_W-1:0] val = 24'h000000;
  logic [WORD_W-1:0] ex [6];
  int num_errors = 0;
  int compares = 0;
  int cyc = 0;

  saw_top dut (.*);
  saw_proc_model model (.clk(CORE_CLK), .go(go), .kind(kind), .val(val), .word(ANGLE_PROC_WORD),
    .data(CPU_DATA_LINES), .ld_n({LEVEL_WR_N, COS_CTRL_WR_N, SIN_CTRL_WR_N, ANGLE_LOAD_N, COSINE_LOAD_N, SINE_LOAD_N}));

  always #20 CORE_CLK = ~CORE_CLK;

  function automatic logic [WORD_W-1:0] fit(int k, logic [WORD_W-1:0] v);
    case (k)
      0, 1: return {3'h0, v[CODE_W-1:0]};
      2: return v;
      3: return {16'h0000, v[7:0]};
      4: return {8'h00, v[15:0]};
      default: return {12'h000, v[11:0]};
    endcase
  endfunction

  task automatic finish_test();
    if (num_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(logic [WORD_W-1:0] got, logic [WORD_W-1:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_all();
    chk({3'h0, SIN_POLARITY, SIN_TAP_SEL, SIN_FINE_CODE}, ex[0]);
    chk({3'h0, COS_POLARITY, COS_TAP_SEL, COS_FINE_CODE}, ex[1]);
    chk(ANGLE_OUT, ex[2]);
    chk({16'h0000, SIN_CTRL_OUT}, ex[3]);
    chk({8'h00, COS_CTRL_OUT}, ex[4]);
    chk({12'h000, LEVEL_CODE}, ex[5]);
  endtask

  // Sends one word; with a long gap also measures the channel hold width
  task automatic load(int k, logic [WORD_W-1:0] v, int gap);
    logic [WORD_W-1:0] e;
    logic [WORD_W-1:0] h;
    int n;
    e = fit(k, v);
    h = 24'h000000;
    n = (SETTLE_COUNT == 8'h00) ? 1 : int'(SETTLE_COUNT);
    @(posedge CORE_CLK);
    go <= 1'b1;
    kind <= 3'(k);
    val <= v;
    @(posedge CORE_CLK);
    go <= 1'b0;
    repeat (gap)
    begin
      @(negedge CORE_CLK);
      // Kept four-state so an unknown hold cannot count as zero
      h = h + ((k == 0) ? 24'(SIN_HOLD) : (k == 1) ? 24'(COS_HOLD) : 24'h000000);
    end
    if (k < 2 && gap > 12)
      chk(h, (e == ex[k]) ? 24'h000000 : 24'(n + 1));
    ex[k] = e;
  endtask

  always @(posedge CORE_CLK)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      num_errors++;
      finish_test();
    end
  end

  initial
  begin
    void'($urandom(32'hACF3));
    for (int i = 0; i < 6; i++)
      ex[i] = '0;
    repeat (4) @(negedge CORE_CLK);
    RST = 1'b0;
    repeat (3) @(negedge CORE_CLK);
    check_all();
    for (int i = 0; i < 12; i++)
    begin
      @(negedge CORE_CLK);
      SETTLE_COUNT = 8'($urandom % 4);
      for (int k = 0; k < 6; k++)
        load(k, 24'($urandom), 14);
      load(i % 2, ex[i % 2], 14);
      check_all();
    end
    // Back-to-back loads, extreme codes, restart in mid-hold
    load(0, 24'hFFFFFF, 1);
    load(0, 24'h100000, 1);
    load(2, 24'hFFFFFF, 14);
    check_all();
    RST = 1'b1;
    repeat (4) @(negedge CORE_CLK);
    RST = 1'b0;
    for (int i = 0; i < 6; i++)
      ex[i] = '0;
    repeat (3) @(negedge CORE_CLK);
    check_all();
    finish_test();
  end
endmodule // synchro_angle_word_registers_tb
